// *** pkg/pfm_pkg.sv ***
// Constants, types and layout for the pulse frequency meter
//
// How it works
// - Count phase A and phase B pulses and derive frequency automatically.
// - Averaging count accepts 1 to 100 and sets how many samples average.
// - Averaging count of one publishes each raw sample directly.
// - Publish mean after configured sample count, then slide the window.
// - Window length selectable as 0.01 s, 0.1 s or 1 s.
// - Sample in hertz equals window pulse count divided by window seconds.
// - No pulses in a window gives a frequency of zero.
// - Down counting gives a negative, signed frequency.
// - Integer count per window; the count restarts each window, and a pulse on the boundary goes to the next window.
// - Doubling and quadrupling modes report the multiplied count rate.
// - Phase-A-only modes leave phase B free as plain input, no interrupt.
// - Command on starts measuring and sets status word bit 4.
// - While command is on the latest value is kept published.
// - Command off stops, clears bit 4 and forces value to zero.
package pfm_pkg;

  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned UNIT_10MS_US   = 10000;
  localparam int unsigned UNIT_100MS_US  = 100000;
  localparam int unsigned UNIT_1S_US     = 1000000;
  localparam int unsigned WIN_10MS_CYC   = UNIT_10MS_US * CLK_MHZ;
  localparam int unsigned WIN_100MS_CYC  = UNIT_100MS_US * CLK_MHZ;
  localparam int unsigned WIN_1S_CYC     = UNIT_1S_US * CLK_MHZ;
  localparam int unsigned SCALE_10MS     = UNIT_1S_US / UNIT_10MS_US;
  localparam int unsigned SCALE_100MS    = UNIT_1S_US / UNIT_100MS_US;
  localparam int unsigned SCALE_1S       = UNIT_1S_US / UNIT_1S_US;

  localparam logic [3:0]  OFF_CTRL       = 4'h0;
  localparam logic [3:0]  OFF_AVG        = 4'h4;
  localparam logic [3:0]  OFF_STATUS     = 4'h8;
  localparam logic [3:0]  OFF_VALUE      = 4'hC;

  localparam int unsigned CTRL_CMD_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_UNIT_LSB  = 4;
  localparam int unsigned STAT_MEAS_BIT  = 4;

  localparam logic [6:0]  AVG_MIN        = 7'h01;
  localparam logic [6:0]  AVG_MAX        = 7'h64;
  localparam logic [6:0]  AVG_RST        = 7'h01;

  typedef enum logic [2:0] {
    MODE_P1_X1  = 3'b000,
    MODE_P1_X2  = 3'b001,
    MODE_CWCCW  = 3'b010,
    MODE_P2_X1  = 3'b011,
    MODE_P2_X2  = 3'b100,
    MODE_P2_X4  = 3'b101,
    MODE_AO_X1  = 3'b110,
    MODE_AO_X2  = 3'b111
  } pfm_mode_t;

  typedef enum logic [1:0] {
    UNIT_10MS  = 2'b00,
    UNIT_100MS = 2'b01,
    UNIT_1S    = 2'b10,
    UNIT_RSV   = 2'b11
  } pfm_unit_t;

  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } pfm_div_t;

  typedef struct packed {
    pfm_unit_t  unit;
    pfm_mode_t  mode;
    logic [6:0] avg;
  } pfm_cfg_t;

  typedef struct packed {
    logic up;
    logic dn;
  } pfm_step_t;

endpackage : pfm_pkg

// *** rtl/pfm_top.sv ***
// Pulse frequency meter for counter channel one with Avalon-MM registers
`timescale 1ns/100ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
#(
  parameter int unsigned WIN0_CYC = WIN_10MS_CYC,
  parameter int unsigned WIN1_CYC = WIN_100MS_CYC,
  parameter int unsigned WIN2_CYC = WIN_1S_CYC,
  parameter int unsigned AVG_DEPTH = 100
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        phase_a_i,
  input  wire logic        phase_b_i,
  output logic      [31:0] freq_value_o,
  output logic             measuring_o,
  output logic             phase_b_gp_o
);

  // Averaging buffer must cover the largest count; divider needs 41 cycles per window
  if (AVG_DEPTH != 32'(AVG_MAX) || WIN0_CYC < 42 || WIN1_CYC < 42
      || WIN2_CYC < 42) begin : g_param_check
    $error("pfm_top: unsupported parameter value");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic             ack_q;
  logic [31:0]      rdata_q;
  logic [31:0]      ctrl_q;
  logic [6:0]       avg_q;
  logic             meas_q;
  logic signed [31:0] freq_q;
  logic             wr_en;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_en             = avs_write_i & ack_q & avs_byteenable_i[0];
  assign avs_readdata_o    = rdata_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h0;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        OFF_CTRL:   rdata_q <= {24'h0, ctrl_q[7:0]};
        OFF_AVG:    rdata_q <= {25'h0, avg_q};
        // Status word bit 4
        OFF_STATUS: rdata_q <= {27'h0, meas_q, 4'h0};
        OFF_VALUE:  rdata_q <= freq_q;
        default:    rdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= 32'h0;
    end else if (wr_en && avs_address_i == OFF_CTRL) begin
      ctrl_q <= {24'h0, 1'b0, avs_writedata_i[6:0]};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avg_q <= AVG_RST;
    end else if (wr_en && avs_address_i == OFF_AVG) begin
      if (avs_writedata_i[6:0] < AVG_MIN) begin
        avg_q <= AVG_MIN;
      end else if (avs_writedata_i[6:0] > AVG_MAX) begin
        avg_q <= AVG_MAX;
      end else begin
        avg_q <= avs_writedata_i[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect

  logic [1:0] a_sync_q;
  logic [1:0] b_sync_q;
  logic       a_prev_q;
  logic       b_prev_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      a_sync_q <= 2'b00;
      b_sync_q <= 2'b00;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_sync_q <= {a_sync_q[0], phase_a_i};
      b_sync_q <= {b_sync_q[0], phase_b_i};
      a_prev_q <= a_sync_q[1];
      b_prev_q <= b_sync_q[1];
    end
  end

  logic a_r, a_f, b_r, b_f, a_l, b_l;
  assign a_l = a_sync_q[1];
  assign b_l = b_sync_q[1];
  assign a_r = a_l & ~a_prev_q;
  assign a_f = ~a_l & a_prev_q;
  assign b_r = b_l & ~b_prev_q;
  assign b_f = ~b_l & b_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration latched at start

  pfm_cfg_t cfg_q;
  logic     cmd;
  assign cmd = ctrl_q[CTRL_CMD_BIT];

  assign phase_b_gp_o = (cfg_q.mode == MODE_AO_X1 || cfg_q.mode == MODE_AO_X2) ? b_l : 1'b0;

  // Count step decoder per input mode
  pfm_step_t step;
  always_comb begin
    step = '0;
    case (cfg_q.mode)
      MODE_P1_X1: begin
        step.up = a_r & ~b_l;
        step.dn = a_r & b_l;
      end
      MODE_P1_X2: begin
        step.up = (a_r | a_f) & ~b_l;
        step.dn = (a_r | a_f) & b_l;
      end
      MODE_CWCCW: begin
        step.up = a_r & ~b_r;
        step.dn = b_r & ~a_r;
      end
      MODE_P2_X1: begin
        step.up = a_r & ~b_l;
        step.dn = a_f & ~b_l;
      end
      MODE_P2_X2: begin
        step.up = (a_r & ~b_l) | (a_f & b_l);
        step.dn = (a_r & b_l) | (a_f & ~b_l);
      end
      MODE_P2_X4: begin
        step.up = (a_r & ~b_l) | (a_f & b_l) | (b_r & a_l) | (b_f & ~a_l);
        step.dn = (a_r & b_l) | (a_f & ~b_l) | (b_r & ~a_l) | (b_f & a_l);
      end
      MODE_AO_X1: begin
        step.up = a_r;
        step.dn = 1'b0;
      end
      MODE_AO_X2: begin
        step.up = a_r | a_f;
        step.dn = 1'b0;
      end
      default: begin
        step = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, stop and window timing

  logic [31:0] win_cnt_q;
  logic [31:0] win_len;
  logic        win_end;

  always_comb begin
    case (cfg_q.unit)
      UNIT_10MS:  win_len = WIN0_CYC;
      UNIT_100MS: win_len = WIN1_CYC;
      default:    win_len = WIN2_CYC;
    endcase
  end

  assign win_end = meas_q && (win_cnt_q == win_len - 32'h1);

  // start sets flag; stop clears it; restart only after stop
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meas_q <= 1'b0;
      cfg_q  <= '{unit: UNIT_10MS, mode: MODE_P1_X1, avg: AVG_RST};
    end else if (!meas_q && cmd) begin
      meas_q <= 1'b1;
      cfg_q  <= '{unit: pfm_unit_t'(ctrl_q[CTRL_UNIT_LSB +: 2]),
                  mode: pfm_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]), avg: avg_q};
    end else if (!cmd) begin
      meas_q <= 1'b0;
    end
  end
  assign measuring_o = meas_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt_q <= 32'h0;
    end else if (!meas_q || win_end) begin
      win_cnt_q <= 32'h0;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
    end
  end

  // pulse count; pulses at the boundary go to the next window
  logic signed [31:0] cnt_q;
  logic signed [31:0] cnt_step;
  assign cnt_step = step.up ? 32'sh1 : (step.dn ? -32'sh1 : 32'sh0);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 32'sh0;
    end else if (!meas_q) begin
      cnt_q <= 32'sh0;
    end else if (win_end) begin
      cnt_q <= cnt_step;
    end else begin
      cnt_q <= cnt_q + cnt_step;
    end
  end

  // count over window seconds; zero count gives zero; signed
  logic signed [31:0] sample;
  always_comb begin
    case (cfg_q.unit)
      UNIT_10MS:  sample = 32'(cnt_q * $signed(32'(SCALE_10MS)));
      UNIT_100MS: sample = 32'(cnt_q * $signed(32'(SCALE_100MS)));
      default:    sample = 32'(cnt_q * $signed(32'(SCALE_1S)));
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Moving average

  logic signed [31:0] buf_q [AVG_DEPTH];
  logic        [6:0]  wr_q;
  logic        [6:0]  fill_q;
  logic signed [39:0] sum_q;
  logic signed [39:0] sum_d;
  logic               full_d;

  assign sum_d  = sum_q + 40'(sample) - ((fill_q == cfg_q.avg) ? 40'(buf_q[wr_q]) : 40'sh0);
  assign full_d = (fill_q == cfg_q.avg) || (fill_q + 7'h1 == cfg_q.avg);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q   <= 7'h0;
      fill_q <= 7'h0;
      sum_q  <= 40'sh0;
    end else if (!meas_q) begin
      wr_q   <= 7'h0;
      fill_q <= 7'h0;
      sum_q  <= 40'sh0;
    end else if (win_end) begin
      sum_q  <= sum_d;
      wr_q   <= (wr_q + 7'h1 == cfg_q.avg) ? 7'h0 : wr_q + 7'h1;
      fill_q <= (fill_q == cfg_q.avg) ? fill_q : fill_q + 7'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (win_end) begin
      buf_q[wr_q] <= sample;
    end
  end

  // Divider: restoring, one quotient bit per clock
  pfm_div_t    div_st_q;
  logic [39:0] dvd_q;
  logic [7:0]  rem_q;
  logic [5:0]  bit_q;
  logic        neg_q;
  logic [7:0]  trial;
  logic        fits;

  assign trial = {rem_q[6:0], dvd_q[39]};
  assign fits  = trial >= {1'b0, cfg_q.avg};

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_st_q <= DIV_IDLE;
      dvd_q    <= 40'h0;
      rem_q    <= 8'h0;
      bit_q    <= 6'h0;
      neg_q    <= 1'b0;
    end else begin
      case (div_st_q)
        DIV_IDLE: begin
          if (win_end && full_d && cfg_q.avg != AVG_MIN) begin
            div_st_q <= DIV_RUN;
            dvd_q    <= sum_d[39] ? 40'(-sum_d) : sum_d;
            neg_q    <= sum_d[39];
            rem_q    <= 8'h0;
            bit_q    <= 6'h27;
          end
        end
        DIV_RUN: begin
          rem_q <= fits ? trial - {1'b0, cfg_q.avg} : trial;
          dvd_q <= {dvd_q[38:0], fits};
          bit_q <= bit_q - 6'h1;
          if (!meas_q || bit_q == 6'h0) begin
            div_st_q <= DIV_IDLE;
          end
        end
        default: begin
          div_st_q <= DIV_IDLE;
        end
      endcase
    end
  end

  logic div_done;
  assign div_done = (div_st_q == DIV_RUN) && (bit_q == 6'h0);

  // raw publish; latest value; zero on stop; zero before first
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      freq_q <= 32'sh0;
    end else if (!meas_q) begin
      freq_q <= 32'sh0;
    end else if (win_end && cfg_q.avg == AVG_MIN) begin
      freq_q <= sample;
    end else if (div_done) begin
      freq_q <= neg_q ? -32'({dvd_q[38:0], fits}) : 32'({dvd_q[38:0], fits});
    end
  end
  assign freq_value_o = freq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_start;
    !meas_q && cmd;
  endsequence

  sequence s_window_raw;
    win_end && cfg_q.avg == AVG_MIN;
  endsequence

  start_sets_flag_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) s_start |=> meas_q && measuring_o)
    else $error("flag not set after start");

  stop_zeroes_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) $fell(meas_q) |=> freq_q == 32'sh0)
    else $error("stop did not clear value");

  idle_zero_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) (meas_q && fill_q == 7'h0) |-> freq_q == 32'sh0)
    else $error("value nonzero before first window");

  raw_publish_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) s_window_raw ##1 meas_q |-> freq_q == $past(sample))
    else $error("raw sample not published");

  window_len_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) meas_q |-> win_cnt_q < win_len)
    else $error("window length wrong");

  zero_count_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) (win_end && cnt_q == 32'sh0) |-> sample == 32'sh0)
    else $error("zero count gave nonzero sample");

  sign_follow_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) win_end && cnt_q < 0 |-> sample < 0)
    else $error("down count not negative");

  avg_range_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) avg_q >= AVG_MIN && avg_q <= AVG_MAX)
    else $error("averaging count out of range");

  avg_done_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (div_st_q == DIV_IDLE && win_end && full_d && cfg_q.avg != AVG_MIN) |->
    (##[1:40] !meas_q) or (##40 div_done))
    else $error("average not produced in 40 cycles");

  bus_answer_a: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i) (avs_read_i || avs_write_i) && !ack_q |=> !avs_waitrequest_o)
    else $error("bus not answered next cycle");

endmodule : pfm_top
`default_nettype wire

// *** tb/pfm_src_model.sv ***
// Pulse source model driving the phase A and phase B pins
`timescale 1ns/100ps
`default_nettype none
module pfm_src_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       dn_i,
  input  wire logic       quad_i,
  input  wire logic [7:0] half_i,
  output logic            phase_a_o,
  output logic            phase_b_o
);
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] st_q  = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // One step each half_i cycles; quadrature steps run backwards when down
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (cnt_q >= half_i - 8'h01) begin
        cnt_q <= 8'h00;
        st_q  <= (quad_i && dn_i) ? st_q - 2'h1 : st_q + 2'h1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // phase A always driven
  assign phase_a_o = quad_i ? (st_q[1] ^ st_q[0]) : st_q[0];
  // phase B in two-input modes; A leads B when counting up
  assign phase_b_o = quad_i ? st_q[1] : dn_i;
endmodule : pfm_src_model
`default_nettype wire

// *** tb/testbench.sv ***
// Register-level test bench for the pulse frequency meter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pfm_pkg::*;
  typedef struct packed {
    logic [2:0]  mode;
    logic [1:0]  unit;
    logic        quad;
    logic        dn;
    logic        en;
    logic [31:0] exp;
  } pfm_case_t;
  localparam pfm_case_t CASES [13] = '{
    '{3'h0, 2'h0, 1'b0, 1'b0, 1'b1, 32'h000003E8}, '{3'h0, 2'h0, 1'b0, 1'b1, 1'b1, 32'hFFFFFC18},
    '{3'h1, 2'h0, 1'b0, 1'b0, 1'b1, 32'h000007D0}, '{3'h2, 2'h0, 1'b0, 1'b0, 1'b1, 32'h000003E8},
    '{3'h3, 2'h0, 1'b1, 1'b0, 1'b1, 32'h000001F4}, '{3'h4, 2'h0, 1'b1, 1'b1, 1'b1, 32'hFFFFFC18},
    '{3'h5, 2'h0, 1'b1, 1'b0, 1'b1, 32'h000007D0}, '{3'h6, 2'h0, 1'b0, 1'b0, 1'b1, 32'h000003E8},
    '{3'h7, 2'h0, 1'b0, 1'b0, 1'b1, 32'h000007D0}, '{3'h0, 2'h1, 1'b0, 1'b0, 1'b1, 32'h000000C8},
    '{3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 32'h00000028}, '{3'h0, 2'h3, 1'b0, 1'b0, 1'b1, 32'h00000028},
    '{3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h00000000}};
  logic        mclk;
  logic        reset_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        phase_a;
  logic        phase_b;
  logic [31:0] freq_value;
  logic        measuring;
  logic        phase_b_gp;
  logic        src_en;
  logic        src_dn;
  logic        src_quad;
  logic [7:0]  src_half;
  logic [31:0] rd;
  int          mismatches;
  int          checks_done;
  pfm_top #(.WIN0_CYC(100), .WIN1_CYC(200), .WIN2_CYC(400), .AVG_DEPTH(100)) i_dut (
    .mclk_i(mclk), .reset_n_i(reset_n), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .phase_a_i(phase_a),
    .phase_b_i(phase_b), .freq_value_o(freq_value), .measuring_o(measuring),
    .phase_b_gp_o(phase_b_gp));
  pfm_src_model i_src (.clk_i(mclk), .en_i(src_en), .dn_i(src_dn), .quad_i(src_quad),
    .half_i(src_half), .phase_a_o(phase_a), .phase_b_o(phase_b));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus and compare tasks
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] data);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus_xfer
  task automatic bus_write(input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus_xfer(1'b1, a, wd, be, d);
  endtask : bus_write
  task automatic bus_read(input logic [3:0] a, output logic [31:0] data);
    bus_xfer(1'b0, a, 32'h00000000, 4'hF, data);
  endtask : bus_read
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic start(input logic [2:0] mode, input logic [1:0] unit);
    bus_write(OFF_CTRL, {26'h0, unit, mode, 1'b1}, 4'hF);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000000);
    bus_read(OFF_STATUS, rd);
    check({31'h0, rd[STAT_MEAS_BIT]}, 32'h00000001);
    check({31'h0, measuring}, 32'h00000001);
  endtask : start
  task automatic stop();
    bus_write(OFF_CTRL, 32'h00000000, 4'hF);
    bus_read(OFF_STATUS, rd);
    check({31'h0, rd[STAT_MEAS_BIT]}, 32'h00000000);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000000);
    check({31'h0, measuring}, 32'h00000000);
    check(freq_value, 32'h00000000);
  endtask : stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    mismatches = 0;
    checks_done = 0;
    reset_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    src_en = 1'b0;
    src_dn = 1'b0;
    src_quad = 1'b0;
    src_half = 8'h05;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus_read(OFF_AVG, rd);
    check(rd, 32'h00000001);
    bus_read(OFF_STATUS, rd);
    check(rd, 32'h00000000);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000000);
    bus_read(4'h2, rd);
    check(rd, 32'h00000000);
    bus_write(OFF_AVG, 32'h00000000, 4'hF);
    bus_read(OFF_AVG, rd);
    check(rd, 32'h00000001);
    bus_write(OFF_AVG, 32'h0000007F, 4'hF);
    bus_read(OFF_AVG, rd);
    check(rd, 32'h00000064);
    bus_write(OFF_AVG, 32'h00000005, 4'h0);
    bus_read(OFF_AVG, rd);
    check(rd, 32'h00000064);
    $display("test registers done");
    bus_write(OFF_AVG, 32'h00000001, 4'hF);
    for (int i = 0; i < 13; i++) begin
      src_en   <= CASES[i].en;
      src_dn   <= CASES[i].dn;
      src_quad <= CASES[i].quad;
      start(CASES[i].mode, CASES[i].unit);
      repeat ((CASES[i].unit == 2'h0 ? 300 : CASES[i].unit == 2'h1 ? 600 : 1200) + 50)
        @(posedge mclk);
      bus_read(OFF_VALUE, rd);
      check(rd, CASES[i].exp);
      check(freq_value, CASES[i].exp);
      stop();
    end
    $display("test modes done");
    src_en <= 1'b1;
    src_dn <= 1'b0;
    src_quad <= 1'b0;
    src_half <= 8'h06;
    start(3'h0, 2'h0);
    repeat (250) @(posedge mclk);
    bus_read(OFF_VALUE, rd);
    check({31'h0, (rd === 32'h00000320) || (rd === 32'h00000384)}, 32'h00000001);
    stop();
    bus_write(OFF_AVG, 32'h00000003, 4'hF);
    start(3'h0, 2'h0);
    repeat (150) @(posedge mclk);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000000);
    repeat (300) @(posedge mclk);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000341);
    check(freq_value, 32'h00000341);
    bus_write(OFF_CTRL, 32'h00000021, 4'hF);
    repeat (400) @(posedge mclk);
    bus_read(OFF_VALUE, rd);
    check(rd, 32'h00000341);
    stop();
    $display("test averaging done");
    src_half <= 8'h05;
    bus_write(OFF_AVG, 32'h00000001, 4'hF);
    start(3'h6, 2'h0);
    src_dn <= 1'b1;
    repeat (6) @(posedge mclk);
    check({31'h0, phase_b_gp}, 32'h00000001);
    src_dn <= 1'b0;
    repeat (6) @(posedge mclk);
    check({31'h0, phase_b_gp}, 32'h00000000);
    stop();
    src_dn <= 1'b1;
    start(3'h0, 2'h0);
    repeat (6) @(posedge mclk);
    check({31'h0, phase_b_gp}, 32'h00000000);
    stop();
    $display("test phase b input done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
